// >>> cap_defines.svh
// Constants for the core arithmetic pipeline: widths, addresses, status layout, timing
// Assumes inclusion by bare name before any module that uses these macros
`ifndef CAP_DEFINES_SVH
`define CAP_DEFINES_SVH
`define CAP_DATA_W      8
`define CAP_IR_W        12
`define CAP_PM_WORDS    1024
`define CAP_PC_W        10
`define CAP_FA_W        5
`define CAP_STK_DEPTH   4
`define CAP_SP_W        2
`define CAP_PC_RESET    10'h3FF
`define CAP_STAT_RESET  8'h00
`define CAP_PCL_ADDR    5'h02
`define CAP_STAT_ADDR   5'h03
`define CAP_ST_C        0
`define CAP_ST_DC       1
`define CAP_ST_Z        2
`define CAP_FL_C        3'h1
`define CAP_FL_Z        3'h4
`define CAP_FL_ALL      3'h7
`define CAP_IR_D        5
`define CAP_RET_CODE    5'h01
`define CAP_REF_CYC_NS  200
`define CAP_REF_CLK_MHZ 20
`define CAP_PHASES      (`CAP_REF_CYC_NS * `CAP_REF_CLK_MHZ / 1000)
`define CAP_CLK_NS      10
`define CAP_CYC_NS      (`CAP_PHASES * `CAP_CLK_NS)
`endif

// >>> cap_pkg.sv
// Types shared by the core arithmetic pipeline modules
// Assumes nothing beyond a SystemVerilog compiler
package cap_pkg;
   typedef enum logic [1:0] {
      PH_ONE   = 2'b00,
      PH_TWO   = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR  = 2'b11
   } cap_phase_t;

   typedef enum logic [3:0] {
      AU_PASS_A = 4'h0, AU_PASS_B = 4'h1, AU_ADD = 4'h2, AU_SUB = 4'h3,
      AU_AND    = 4'h4, AU_IOR    = 4'h5, AU_XOR = 4'h6, AU_COM = 4'h7,
      AU_INC    = 4'h8, AU_DEC    = 4'h9, AU_RL  = 4'hA, AU_RR  = 4'hB,
      AU_SWAP   = 4'hC, AU_CLR    = 4'hD
   } cap_alu_op_t;

   typedef enum logic [3:0] {
      FOP_MISC = 4'h0, FOP_STORE_W = 4'h1, FOP_CLEAR = 4'h2, FOP_SUB   = 4'h3,
      FOP_DEC  = 4'h4, FOP_IOR     = 4'h5, FOP_AND   = 4'h6, FOP_XOR   = 4'h7,
      FOP_ADD  = 4'h8, FOP_MOVE    = 4'h9, FOP_COMP  = 4'hA, FOP_INC   = 4'hB,
      FOP_ROR  = 4'hC, FOP_ROL     = 4'hD, FOP_SWAP  = 4'hE, FOP_SPARE = 4'hF
   } cap_fop_t;

   typedef enum logic [1:0] {
      LOP_LOAD = 2'b00,
      LOP_ADD  = 2'b01,
      LOP_AND  = 2'b10,
      LOP_XOR  = 2'b11
   } cap_lop_t;

   typedef struct packed {
      cap_alu_op_t op;
      logic [2:0]  fl;
      logic        rd;
      logic        lit;
      logic        to_w;
      logic        to_f;
      logic        go;
      logic        call;
      logic        ret;
   } cap_dec_t;
endpackage

// >>> cap_phase_gen.sv
// Four-phase sequencer dividing the core clock into instruction-cycle phases
// Assumes a single clock and an asynchronous active-high reset
module cap_phase_gen (
   input  wire logic                clk,   // Core clock
   input  wire logic                rst,   // Async reset, active high
   output      cap_pkg::cap_phase_t phase  // Current phase, registered
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= cap_pkg::PH_ONE;
      end else begin
         unique case (phase)
            cap_pkg::PH_ONE:   phase <= cap_pkg::PH_TWO;
            cap_pkg::PH_TWO:   phase <= cap_pkg::PH_THREE;
            cap_pkg::PH_THREE: phase <= cap_pkg::PH_FOUR;
            cap_pkg::PH_FOUR:  phase <= cap_pkg::PH_ONE;
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_cycle;
      phase == cap_pkg::PH_TWO ##1 phase == cap_pkg::PH_THREE ##1 phase == cap_pkg::PH_FOUR ##1
         phase == cap_pkg::PH_ONE;
   endsequence
   property p_four_phases;
      phase == cap_pkg::PH_ONE |=> s_cycle;
   endproperty
   a_four_phases: assert property (p_four_phases) else $error("phase order broken");
endmodule

// >>> cap_arith_unit.sv
// Combinational 8-bit arithmetic unit with carry, digit carry and zero outputs
// Assumes operands are stable for the clock in which the result is captured
module cap_arith_unit (
   input  wire logic [7:0]           a,     // Working register operand
   input  wire logic [7:0]           b,     // File or immediate operand
   input  wire logic                 cin,   // Carry in for rotates
   input  wire cap_pkg::cap_alu_op_t op,    // Operation select
   output      logic [7:0]           y,     // Result
   output      logic                 c,     // Carry or no-borrow out
   output      logic                 dc,    // Digit carry or no-borrow out
   output      logic                 z      // Result is zero
);
   logic [4:0] nib;

   always_comb begin
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      y   = b;
      c   = cin;
      dc  = 1'b0;
      unique case (op)
         cap_pkg::AU_PASS_A: y = a;
         cap_pkg::AU_PASS_B: y = b;
         cap_pkg::AU_ADD: begin
            {c, y} = {1'b0, a} + {1'b0, b};
            dc     = nib[4];
         end
         cap_pkg::AU_SUB: begin
            y  = b - a;
            c  = (b >= a);
            dc = (b[3:0] >= a[3:0]);
         end
         cap_pkg::AU_AND:  y = a & b;
         cap_pkg::AU_IOR:  y = a | b;
         cap_pkg::AU_XOR:  y = a ^ b;
         cap_pkg::AU_COM:  y = ~b;
         cap_pkg::AU_INC:  y = b + 8'h01;
         cap_pkg::AU_DEC:  y = b - 8'h01;
         cap_pkg::AU_RL: begin
            y = {b[6:0], cin};
            c = b[7];
         end
         cap_pkg::AU_RR: begin
            y = {cin, b[7:1]};
            c = b[0];
         end
         cap_pkg::AU_SWAP: y = {b[3:0], b[7:4]};
         cap_pkg::AU_CLR:  y = 8'h00;
         default:          y = b;
      endcase
      z = (y == 8'h00);
   end
endmodule

// >>> cap_core.sv
// Execution core: two-stage fetch/execute pipeline, working register, status, stack
// Assumes program and data memories on the same clock, answering within one clock
`include "cap_defines.svh"
module cap_core (
   input  wire logic [0:0]                clk,       // Core clock
   input  wire logic [0:0]                rst,       // Async reset, active high
   output      logic [`CAP_PC_W-1:0]      pm_addr,   // Program word address
   input  wire logic [`CAP_IR_W-1:0]      pm_rdata,  // Program word read data
   output      logic [`CAP_FA_W-1:0]      dm_addr,   // Data memory address
   output      logic                      dm_re,     // Data read strobe
   input  wire logic [`CAP_DATA_W-1:0]    dm_rdata,  // Data read data
   output      logic                      dm_we,     // Data write strobe
   output      logic [`CAP_DATA_W-1:0]    dm_wdata,  // Data write data
   output      logic [`CAP_DATA_W-1:0]    work_reg,  // Working register view
   output      logic [`CAP_DATA_W-1:0]    status     // Status register view
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   cap_pkg::cap_phase_t       ph;
   cap_pkg::cap_dec_t         dx;
   cap_pkg::cap_dec_t         df;
   logic [`CAP_IR_W-1:0]      fetch_q;
   logic [`CAP_IR_W-1:0]      ir_q;
   logic                      fetch_v_q;
   logic                      ir_v_q;
   logic                      br_q;
   logic                      take_br;
   logic [`CAP_PC_W-1:0]      pc_q;
   logic [`CAP_PC_W-1:0]      tgt_q;
   logic [`CAP_PC_W-1:0]      tgt_d;
   logic [`CAP_PC_W-1:0]      stk_q [`CAP_STK_DEPTH];
   logic [`CAP_SP_W-1:0]      sp_q;
   logic [`CAP_DATA_W-1:0]    w_q;
   logic [`CAP_DATA_W-1:0]    status_q;
   logic [`CAP_DATA_W-1:0]    status_d;
   logic [`CAP_DATA_W-1:0]    opnd_q;
   logic [`CAP_DATA_W-1:0]    res_q;
   logic                      res_c_q;
   logic                      res_dc_q;
   logic                      res_z_q;
   logic [`CAP_DATA_W-1:0]    sfr_rd;
   logic [`CAP_DATA_W-1:0]    alu_y;
   logic                      alu_c;
   logic                      alu_dc;
   logic                      alu_z;
   logic [`CAP_FA_W-1:0]      dm_addr_q;
   logic                      dm_re_q;
   logic                      dm_we_q;
   logic [`CAP_DATA_W-1:0]    dm_wdata_q;
   logic                      exec;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic is_core_sfr(input logic [`CAP_FA_W-1:0] a);
      return (a == `CAP_PCL_ADDR) || (a == `CAP_STAT_ADDR);
   endfunction

   function automatic cap_pkg::cap_dec_t decode(input logic [`CAP_IR_W-1:0] ir);
      cap_pkg::cap_dec_t r;
      r = '{op: cap_pkg::AU_PASS_B, fl: 3'h0, default: 1'b0};
      unique case (ir[11:10])
         2'b11: r.go = 1'b1;
         2'b10: r.call = 1'b1;
         2'b01: begin
            r.lit  = 1'b1;
            r.to_w = 1'b1;
            unique case (cap_pkg::cap_lop_t'(ir[9:8]))
               cap_pkg::LOP_LOAD: r.op = cap_pkg::AU_PASS_B;
               cap_pkg::LOP_ADD: begin
                  r.op = cap_pkg::AU_ADD;
                  r.fl = `CAP_FL_ALL;
               end
               cap_pkg::LOP_AND: begin
                  r.op = cap_pkg::AU_AND;
                  r.fl = `CAP_FL_Z;
               end
               cap_pkg::LOP_XOR: begin
                  r.op = cap_pkg::AU_XOR;
                  r.fl = `CAP_FL_Z;
               end
            endcase
         end
         2'b00: begin
            r.rd   = 1'b1;
            r.to_f = ir[`CAP_IR_D];
            r.to_w = ~ir[`CAP_IR_D];
            r.fl   = `CAP_FL_Z;
            unique case (cap_pkg::cap_fop_t'(ir[9:6]))
               cap_pkg::FOP_MISC, cap_pkg::FOP_SPARE: begin
                  r    = '{op: cap_pkg::AU_PASS_B, fl: 3'h0, default: 1'b0};
                  r.ret = (ir[9:6] == 4'h0) && (ir[4:0] == `CAP_RET_CODE);
               end
               cap_pkg::FOP_STORE_W: begin
                  r.op   = cap_pkg::AU_PASS_A;
                  r.rd   = 1'b0;
                  r.to_f = 1'b1;
                  r.to_w = 1'b0;
                  r.fl   = 3'h0;
               end
               cap_pkg::FOP_CLEAR: begin
                  r.op = cap_pkg::AU_CLR;
                  r.rd = 1'b0;
               end
               cap_pkg::FOP_SUB: begin
                  r.op = cap_pkg::AU_SUB;
                  r.fl = `CAP_FL_ALL;
               end
               cap_pkg::FOP_ADD: begin
                  r.op = cap_pkg::AU_ADD;
                  r.fl = `CAP_FL_ALL;
               end
               cap_pkg::FOP_DEC:  r.op = cap_pkg::AU_DEC;
               cap_pkg::FOP_IOR:  r.op = cap_pkg::AU_IOR;
               cap_pkg::FOP_AND:  r.op = cap_pkg::AU_AND;
               cap_pkg::FOP_XOR:  r.op = cap_pkg::AU_XOR;
               cap_pkg::FOP_MOVE: r.op = cap_pkg::AU_PASS_B;
               cap_pkg::FOP_COMP: r.op = cap_pkg::AU_COM;
               cap_pkg::FOP_INC:  r.op = cap_pkg::AU_INC;
               cap_pkg::FOP_ROR: begin
                  r.op = cap_pkg::AU_RR;
                  r.fl = `CAP_FL_C;
               end
               cap_pkg::FOP_ROL: begin
                  r.op = cap_pkg::AU_RL;
                  r.fl = `CAP_FL_C;
               end
               cap_pkg::FOP_SWAP: begin
                  r.op = cap_pkg::AU_SWAP;
                  r.fl = 3'h0;
               end
            endcase
         end
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Phase sequencer and arithmetic unit
   // ----------------------------------------------------------------
   cap_phase_gen u_phase (
      .clk   (clk),
      .rst   (rst),
      .phase (ph)
   );

   cap_arith_unit u_alu (
      .a   (w_q),
      .b   (opnd_q),
      .cin (status_q[`CAP_ST_C]),
      .op  (dx.op),
      .y   (alu_y),
      .c   (alu_c),
      .dc  (alu_dc),
      .z   (alu_z)
   );

   // ----------------------------------------------------------------
   // Decode, branch target and special register read
   // ----------------------------------------------------------------
   always_comb begin
      dx      = decode(ir_q);
      df      = decode(fetch_q);
      exec    = ir_v_q;
      take_br = exec && (dx.go || dx.call || dx.ret ||
                (dx.to_f && ir_q[`CAP_FA_W-1:0] == `CAP_PCL_ADDR));
      if (dx.go || dx.call) begin
         tgt_d = ir_q[`CAP_PC_W-1:0];
      end else if (dx.ret) begin
         tgt_d = stk_q[sp_q - 2'h1];
      end else begin
         tgt_d = {pc_q[`CAP_PC_W-1:8], res_q};
      end
      unique case (ir_q[`CAP_FA_W-1:0])
         `CAP_PCL_ADDR:  sfr_rd = pc_q[7:0];
         `CAP_STAT_ADDR: sfr_rd = status_q;
         default:        sfr_rd = dm_rdata;
      endcase
   end

   always_comb begin
      status_d = status_q;
      if (dx.to_f && ir_q[`CAP_FA_W-1:0] == `CAP_STAT_ADDR) begin
         status_d = res_q;
      end
      if (dx.fl[`CAP_ST_C]) begin
         status_d[`CAP_ST_C] = res_c_q;
      end
      if (dx.fl[`CAP_ST_DC]) begin
         status_d[`CAP_ST_DC] = res_dc_q;
      end
      if (dx.fl[`CAP_ST_Z]) begin
         status_d[`CAP_ST_Z] = res_z_q;
      end
   end

   // ----------------------------------------------------------------
   // Fetch stage and program counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_q   <= 12'h000;
         fetch_v_q <= 1'b0;
      end else if (ph == cap_pkg::PH_FOUR) begin
         fetch_q   <= pm_rdata;
         fetch_v_q <= ~take_br;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ir_q   <= 12'h000;
         ir_v_q <= 1'b0;
      end else if (ph == cap_pkg::PH_ONE) begin
         ir_q   <= fetch_q;
         ir_v_q <= fetch_v_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_q  <= `CAP_PC_RESET;
         br_q  <= 1'b0;
         tgt_q <= 10'h000;
      end else if (ph == cap_pkg::PH_ONE) begin
         pc_q <= br_q ? tgt_q : pc_q + 10'h001;
         br_q <= 1'b0;
      end else if (ph == cap_pkg::PH_FOUR) begin
         br_q  <= take_br;
         tgt_q <= tgt_d;
      end
   end

   // ----------------------------------------------------------------
   // Return-address stack
   // ----------------------------------------------------------------
   for (genvar i = 0; i < `CAP_STK_DEPTH; i++) begin : g_stk
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            stk_q[i] <= 10'h000;
         end else if (ph == cap_pkg::PH_FOUR && exec && dx.call && sp_q == `CAP_SP_W'(i)) begin
            stk_q[i] <= pc_q;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sp_q <= 2'h0;
      end else if (ph == cap_pkg::PH_FOUR && exec && dx.call) begin
         sp_q <= sp_q + 2'h1;
      end else if (ph == cap_pkg::PH_FOUR && exec && dx.ret) begin
         sp_q <= sp_q - 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // Data memory bus
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dm_addr_q  <= 5'h00;
         dm_re_q    <= 1'b0;
         dm_we_q    <= 1'b0;
         dm_wdata_q <= 8'h00;
      end else begin
         unique case (ph)
            cap_pkg::PH_ONE: begin
               dm_addr_q <= fetch_q[`CAP_FA_W-1:0];
               dm_re_q   <= fetch_v_q && df.rd && !is_core_sfr(fetch_q[`CAP_FA_W-1:0]);
            end
            cap_pkg::PH_TWO: dm_re_q <= 1'b0;
            cap_pkg::PH_THREE: begin
               dm_we_q    <= exec && dx.to_f && !is_core_sfr(ir_q[`CAP_FA_W-1:0]);
               dm_wdata_q <= alu_y;
            end
            cap_pkg::PH_FOUR: dm_we_q <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Operand, result, working register and status
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         opnd_q <= 8'h00;
      end else if (ph == cap_pkg::PH_TWO) begin
         opnd_q <= dx.lit ? ir_q[7:0] : sfr_rd;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_q    <= 8'h00;
         res_c_q  <= 1'b0;
         res_dc_q <= 1'b0;
         res_z_q  <= 1'b0;
      end else if (ph == cap_pkg::PH_THREE) begin
         res_q    <= alu_y;
         res_c_q  <= alu_c;
         res_dc_q <= alu_dc;
         res_z_q  <= alu_z;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_q <= 8'h00;
      end else if (ph == cap_pkg::PH_FOUR && exec && dx.to_w) begin
         w_q <= res_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= `CAP_STAT_RESET;
      end else if (ph == cap_pkg::PH_FOUR && exec) begin
         status_q <= status_d;
      end
   end

   assign pm_addr  = pc_q;
   assign dm_addr  = dm_addr_q;
   assign dm_re    = dm_re_q;
   assign dm_we    = dm_we_q;
   assign dm_wdata = dm_wdata_q;
   assign work_reg = w_q;
   assign status   = status_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_branch;
      ph == cap_pkg::PH_FOUR && take_br;
   endsequence
   sequence s_flush;
      br_q ##1 (!ir_v_q && pc_q == $past(tgt_q));
   endsequence
   property p_branch_flush;
      s_branch |=> s_flush;
   endproperty
   a_branch_flush: assert property (p_branch_flush) else $error("branch did not flush");

   property p_pc_step;
      ph == cap_pkg::PH_ONE && !br_q |=> pc_q == $past(pc_q) + 10'h001;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step");

   property p_rd_phase;
      dm_re_q |-> ph == cap_pkg::PH_TWO && !is_core_sfr(dm_addr_q);
   endproperty
   a_rd_phase: assert property (p_rd_phase) else $error("read outside phase two");

   property p_wr_phase;
      dm_we_q |-> ph == cap_pkg::PH_FOUR && dm_wdata_q == res_q;
   endproperty
   a_wr_phase: assert property (p_wr_phase) else $error("write outside phase four");

   property p_w_commit;
      $changed(w_q) |-> $past(ph) == cap_pkg::PH_FOUR && $past(ir_v_q) && w_q == $past(res_q);
   endproperty
   a_w_commit: assert property (p_w_commit) else $error("working register bad update");

   property p_sub_flags;
      ph == cap_pkg::PH_THREE && dx.op == cap_pkg::AU_SUB |=>
         res_c_q == ($past(opnd_q) >= $past(w_q)) && res_dc_q == ($past(opnd_q[3:0]) >= $past(w_q[3:0]));
   endproperty
   a_sub_flags: assert property (p_sub_flags) else $error("subtract borrow flags wrong");

   property p_zero;
      ph == cap_pkg::PH_THREE |=> res_z_q == (res_q == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_ir_hold;
      $changed(ir_q) |-> $past(ph) == cap_pkg::PH_ONE;
   endproperty
   a_ir_hold: assert property (p_ir_hold) else $error("instruction changed mid cycle");

   property p_fetch_q4;
      $changed(fetch_q) |-> $past(ph) == cap_pkg::PH_FOUR && fetch_q == $past(pm_rdata);
   endproperty
   a_fetch_q4: assert property (p_fetch_q4) else $error("fetch latched wrongly");

   property p_push;
      ph == cap_pkg::PH_FOUR && exec && dx.call |=> sp_q == $past(sp_q) + 2'h1 && br_q;
   endproperty
   a_push: assert property (p_push) else $error("call did not push");
endmodule

// >>> cap_mem_model.sv
// Partner model: program word store and external data byte store
// Assumes the core's one clock; both stores answer in the same clock
module cap_mem_model (
   input  wire logic        clk,      // Core clock
   input  wire logic [9:0]  pm_addr,  // Program word address
   output      logic [11:0] pm_rdata, // Program word
   input  wire logic [4:0]  dm_addr,  // Data address
   input  wire logic        dm_re,    // Read strobe
   output      logic [7:0]  dm_rdata, // Read data
   input  wire logic        dm_we,    // Write strobe
   input  wire logic [7:0]  dm_wdata  // Write data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] prog [0:1023];
   logic [7:0]  data [0:31];
   logic [7:0]  last_q = 8'h00;
   // Whole word on its own bus; data bus is separate
   assign pm_rdata = prog[pm_addr];
   // Outside a read the bus shows the inverse of the last byte
   assign dm_rdata = dm_re ? data[dm_addr] : ~last_q;
   always @(posedge clk) begin
      if (dm_re) last_q <= data[dm_addr];
      if (dm_we) data[dm_addr] <= dm_wdata;
   end
endmodule

// >>> tb_top.sv
// Testbench: runs short programs on the core and checks results
// Assumes the memory model answers in the same clock
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [9:0]  pm_addr;
   logic [11:0] pm_rdata;
   logic [4:0]  dm_addr;
   logic        dm_re;
   logic [7:0]  dm_rdata;
   logic        dm_we;
   logic [7:0]  dm_wdata;
   logic [7:0]  work_reg;
   logic [7:0]  status;
   int          miscompares = 0;
   int          total_checks = 0;
   int          ncyc = 0;
   int          we_t[$];
   int          re_t[$];
   always #5 clk = ~clk;
   cap_core uut (.clk(clk), .rst(rst), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
      .dm_re(dm_re), .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata), .work_reg(work_reg),
      .status(status));
   cap_mem_model mem (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
      .dm_re(dm_re), .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata));
   // ----------------------------------------
   // Strobe time stamps in clocks
   // ----------------------------------------
   always @(posedge clk) begin
      if (dm_we === 1'b1) we_t.push_back(ncyc);
      if (dm_re === 1'b1) re_t.push_back(ncyc);
      ncyc++;
   end
   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_num(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_pc(input logic [9:0] a);
      int n;
      n = 0;
      while (pm_addr !== a && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk_val(pm_addr, a);
      repeat (8) @(posedge clk);
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic scn_reset();
      repeat (4) @(posedge clk);
      chk_val(pm_addr, 12'h3FF);
      chk_val({dm_re, dm_we}, 12'h000);
      chk_val(work_reg, 12'h000);
      chk_val(status, 12'h000);
      rst <= 1'b0;
   endtask
   // Subtract, status read as a file, add, xor, then a jump from word 8 to word 0x20
   task automatic scn_arith();
      wait_pc(10'h020);
      chk_val(mem.data[5'h10], 12'h02B);
      chk_val(mem.data[5'h12], 12'h001);
      chk_val(work_reg, 12'h05A);
      chk_val(status, 12'h003);
      chk_num(we_t.size(), 3);
      chk_num(re_t.size(), 1);
      chk_num(we_t[1] - we_t[0], 8);
      chk_num(we_t[1] - re_t[0], 2);
   endtask
   // Subroutine with a byte borrow, then return
   task automatic scn_call();
      wait_pc(10'h022);
      chk_val(work_reg, 12'h0D6);
      chk_val(mem.data[5'h11], 12'h0D6);
      chk_val(status, 12'h002);
   endtask
   // Rotates, logic ops, swap, step, clear, program counter as a file
   task automatic scn_logic();
      wait_pc(10'h03B);
      chk_val(mem.data[5'h10], 12'h051);
      chk_val(mem.data[5'h11], 12'h0D5);
      chk_val(mem.data[5'h12], 12'h018);
      chk_val(mem.data[5'h13], 12'h028);
      chk_val(mem.data[5'h14], 12'h000);
      chk_val(mem.data[5'h15], 12'h02E);
      chk_val(work_reg, 12'h000);
      chk_val(status, 12'h006);
      chk_num(we_t.size(), 14);
      chk_num(re_t.size(), 10);
   endtask
   initial begin
      for (int i = 0; i < 1024; i++) mem.prog[i] = 12'h000;
      for (int i = 0; i < 32; i++) mem.data[i] = 8'h00;
      mem.prog[0] = 12'h43A; mem.prog[1] = 12'h070; mem.prog[2] = 12'h40F;
      mem.prog[3] = 12'h0F0; mem.prog[4] = 12'h243; mem.prog[5] = 12'h072;
      mem.prog[6] = 12'h5FF; mem.prog[7] = 12'h75A; mem.prog[8] = 12'hC20;
      mem.prog[9] = 12'h4FF; mem.prog[32] = 12'h830; mem.prog[33] = 12'h071;
      mem.prog[34] = 12'h000; mem.prog[48] = 12'h455; mem.prog[49] = 12'h0D0;
      mem.prog[50] = 12'h001; mem.prog[51] = 12'h4EE;
      mem.prog[35] = 12'h330;
      mem.prog[36] = 12'h372;
      mem.prog[37] = 12'h190;
      mem.prog[38] = 12'h172;
      mem.prog[39] = 12'h292;
      mem.prog[40] = 12'h63C;
      mem.prog[41] = 12'h073;
      mem.prog[42] = 12'h3B0;
      mem.prog[43] = 12'h2F2;
      mem.prog[44] = 12'h131;
      mem.prog[45] = 12'h242;
      mem.prog[46] = 12'h074;
      mem.prog[47] = 12'hC34;
      mem.prog[52] = 12'h075;
      mem.prog[53] = 12'h0B4;
      mem.prog[54] = 12'h43A;
      mem.prog[55] = 12'h062;
      mem.prog[56] = 12'h4AA;
      mem.prog[57] = 12'h4BB;
      mem.prog[58] = 12'h73A;
      mem.prog[59] = 12'hC3B;
      scn_reset();
      scn_arith();
      scn_call();
      scn_logic();
      final_report();
   end
   initial begin
      #20000;
      miscompares++;
      final_report();
   end
endmodule
